// File: conv_ctrl_top.sv
// Converter control top: register slave, input routing, sample path,
// overrange monitors, calibration control and interrupt.
// Assumes converter core codes arrive on hclk; bus is a single AHB-Lite slave.
//
// Contract
// - Compare the upper eight magnitude bits of each 12-bit sample.
// - Magnitude is 11 bits; -2048 saturates to 2047; bits 10..3 compared.
// - A flag rises when the byte equals or exceeds its threshold.
// - Both channels share the same two thresholds in dual mode.
// - Each channel drives a high flag and a low flag.
// - A flag holds 8 times 2^N cycles after the last crossing.
// - In single mode a setting routes input A or B to the core.
// - In dual mode a swap setting exchanges the channel inputs.
// - Output samples are two's complement with the input's sign.
// - Dual mode samples on rising edges; single mode on both edges.
// - Offset trim settings occupy addresses 0x330 through 0x34F.
// - Each input has its own full-scale trim for its conversions only.
// - Foreground calibration stops samples; background keeps them.
// - Injected dither is removed from the output samples.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`default_nettype none
module conv_ctrl_top
    import conv_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [11:0] core0_code,
    input wire logic [11:0] core0_dither,
    input wire logic [11:0] core1_code,
    input wire logic [11:0] core1_dither,
    output logic core0_input_b,
    output logic core1_input_b,
    output logic core1_falling_edge,
    output logic [15:0] core0_fs_trim,
    output logic [15:0] core1_fs_trim,
    output logic [31:0] core0_offset_trim,
    output logic [31:0] core1_offset_trim,
    output logic [11:0] chan_a_sample,
    output logic [11:0] chan_b_sample,
    output logic sample_valid,
    output logic cal_halt,
    output logic chan_a_high_flag,
    output logic chan_a_low_flag,
    output logic chan_b_high_flag,
    output logic chan_b_low_flag,
    output logic irq
);
    typedef struct packed {
        logic single_mode;
        logic cal_fg;
        logic cal_start;
        logic single_input_b;
        logic dual_swap;
        logic [7:0] high_threshold;
        logic [7:0] low_threshold;
        logic [2:0] flag_hold_exponent;
        logic [15:0] full_scale_trim_a;
        logic [15:0] full_scale_trim_b;
        logic [7:0][15:0] offset_trim;
        logic [4:0] irq_status;
        logic [4:0] irq_mask;
        logic irq;
        logic [3:0] flags_prev;
        logic wr_ph;
        logic [11:0] addr;
        logic [31:0] hrdata;
        logic core0_b;
        logic core1_b;
        logic core1_fall;
        logic [15:0] core0_fs;
        logic [15:0] core1_fs;
        logic [31:0] core0_off;
        logic [31:0] core1_off;
        logic [11:0] sa;
        logic [11:0] sb;
        logic valid;
    } top_state_type;

    top_state_type s_q, s_d;
    ovr_cfg_if cfg ();
    logic cal_busy;
    logic cal_halt_w;
    logic cal_done;
    logic a_high, a_low, b_high, b_low;
    logic [3:0] flags;
    logic [4:0] events;
    logic addr_ph;
    logic [2:0] trim_idx;
    logic single_mode_w;

    // Offset trim word index: phase, input, core from low to high bit order.
    function automatic logic [2:0] trim_index(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - OFFSET_TRIM_FIRST;
        return rel[4:2];
    endfunction : trim_index

    function automatic logic in_trim_range(input logic [11:0] a);
        return (a >= OFFSET_TRIM_FIRST) && (a <= OFFSET_TRIM_LAST);
    endfunction : in_trim_range

    // Trim pair {phase90, phase0} for a core converting the given input.
    function automatic logic [31:0] trim_pair(input top_state_type t,
                                              input logic core,
                                              input logic in_b);
        logic [2:0] base;
        base = {core, in_b, 1'b0};
        return {t.offset_trim[base + 3'h1], t.offset_trim[base]};
    endfunction : trim_pair

    // Read value of a register, taken from the next state so a write in
    // the preceding data phase is already visible.
    function automatic logic [31:0] read_reg(input top_state_type t,
                                             input logic [11:0] a,
                                             input logic [3:0] f,
                                             input logic busy);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            MODE_CTRL_OFS: begin
                r[MODE_SINGLE_BIT] = t.single_mode;
                r[MODE_CAL_FG_BIT] = t.cal_fg;
            end
            INPUT_ROUTING_OFS: begin
                r[ROUTE_SINGLE_B_BIT] = t.single_input_b;
                r[ROUTE_SWAP_BIT] = t.dual_swap;
            end
            OVR_THRESH_OFS: r[15:0] = {t.low_threshold, t.high_threshold};
            OVR_CFG_OFS: r[2:0] = t.flag_hold_exponent;
            FS_TRIM_A_OFS: r[15:0] = t.full_scale_trim_a;
            FS_TRIM_B_OFS: r[15:0] = t.full_scale_trim_b;
            STATUS_OFS: r[4:0] = {f, busy};
            IRQ_STATUS_OFS: r[4:0] = t.irq_status;
            IRQ_MASK_OFS: r[4:0] = t.irq_mask;
            default: begin
                if (in_trim_range(a)) begin
                    r[15:0] = t.offset_trim[trim_index(a)];
                end
            end
        endcase
        return r;
    endfunction : read_reg

    assign flags = {b_low, b_high, a_low, a_high};
    assign events = {cal_done, flags & ~s_q.flags_prev};
    assign addr_ph = hsel && hready && htrans[1];
    assign trim_idx = trim_index(s_q.addr);

    // Register writes, routing, sample path and interrupt state.
    always_comb begin
        s_d = s_q;
        s_d.cal_start = 1'b0;
        if (s_q.wr_ph) begin
            case (s_q.addr)
                MODE_CTRL_OFS: begin
                    s_d.single_mode = hwdata[MODE_SINGLE_BIT];
                    s_d.cal_fg = hwdata[MODE_CAL_FG_BIT];
                    s_d.cal_start = hwdata[MODE_CAL_START_BIT];
                end
                INPUT_ROUTING_OFS: begin
                    s_d.single_input_b = hwdata[ROUTE_SINGLE_B_BIT];
                    s_d.dual_swap = hwdata[ROUTE_SWAP_BIT];
                end
                OVR_THRESH_OFS: begin
                    s_d.high_threshold = hwdata[7:0];
                    s_d.low_threshold = hwdata[THRESH_LOW_POS +: 8];
                end
                OVR_CFG_OFS: s_d.flag_hold_exponent = hwdata[2:0];
                FS_TRIM_A_OFS: s_d.full_scale_trim_a = hwdata[15:0];
                FS_TRIM_B_OFS: s_d.full_scale_trim_b = hwdata[15:0];
                IRQ_STATUS_OFS: s_d.irq_status = s_q.irq_status & ~hwdata[4:0];
                IRQ_MASK_OFS: s_d.irq_mask = hwdata[4:0];
                default: begin
                    if (in_trim_range(s_q.addr)) begin
                        s_d.offset_trim[trim_idx] = hwdata[15:0];
                    end
                end
            endcase
        end
        // New events are ORed in after the clear, so a set wins.
        s_d.irq_status = s_d.irq_status | events;
        s_d.flags_prev = flags;
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
        // Address phase capture; zero wait states, so hready is always high.
        s_d.wr_ph = addr_ph && hwrite;
        s_d.addr = haddr[11:0];
        if (addr_ph && !hwrite) begin
            s_d.hrdata = read_reg(s_d, haddr[11:0], flags, cal_busy);
        end
        // Single mode feeds the chosen input to both core halves, the second
        // on the falling edge; dual mode feeds one input each, swappable.
        s_d.core0_b = s_d.single_mode ? s_d.single_input_b
                                      : s_d.dual_swap;
        s_d.core1_b = s_d.single_mode ? s_d.single_input_b
                                      : !s_d.dual_swap;
        s_d.core1_fall = s_d.single_mode;
        // Each core takes the trims of the input it converts, never the other.
        s_d.core0_fs = s_d.core0_b ? s_d.full_scale_trim_b
                                   : s_d.full_scale_trim_a;
        s_d.core1_fs = s_d.core1_b ? s_d.full_scale_trim_b
                                   : s_d.full_scale_trim_a;
        s_d.core0_off = trim_pair(s_d, 1'b0, s_d.core0_b);
        s_d.core1_off = trim_pair(s_d, 1'b1, s_d.core1_b);
        // Samples keep their two's complement sign; dither is subtracted.
        // A foreground pass freezes the last sample and drops valid.
        s_d.valid = !cal_halt_w;
        if (!cal_halt_w) begin
            s_d.sa = remove_dither(core0_code, core0_dither);
            s_d.sb = remove_dither(core1_code, core1_dither);
        end
    end

    // Single state register of the top level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.high_threshold <= THRESH_RESET;
            s_q.low_threshold <= THRESH_RESET;
            s_q.flag_hold_exponent <= HOLD_EXP_RESET;
            s_q.full_scale_trim_a <= FS_TRIM_RESET;
            s_q.full_scale_trim_b <= FS_TRIM_RESET;
            s_q.core0_fs <= FS_TRIM_RESET;
            s_q.core1_fs <= FS_TRIM_RESET;
            s_q.core1_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Both monitors read one threshold set.
    assign cfg.high_threshold = s_q.high_threshold;
    assign cfg.low_threshold = s_q.low_threshold;
    assign cfg.flag_hold_exponent = s_q.flag_hold_exponent;

    overrange_channel mon_a (
        .hclk(hclk), .hresetn(hresetn), .sample(s_q.sa),
        .sample_valid(s_q.valid), .cfg(cfg),
        .high_flag(a_high), .low_flag(a_low)
    );
    overrange_channel mon_b (
        .hclk(hclk), .hresetn(hresetn), .sample(s_q.sb),
        .sample_valid(s_q.valid), .cfg(cfg),
        .high_flag(b_high), .low_flag(b_low)
    );
    cal_sequencer cal (
        .hclk(hclk), .hresetn(hresetn), .start(s_q.cal_start),
        .foreground(s_q.cal_fg), .busy(cal_busy), .halt(cal_halt_w),
        .done(cal_done)
    );

    // Outputs, all straight from flip-flops except the tied-off hreadyout and hresp.
    assign hrdata = s_q.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign core0_input_b = s_q.core0_b;
    assign core1_input_b = s_q.core1_b;
    assign core1_falling_edge = s_q.core1_fall;
    assign core0_fs_trim = s_q.core0_fs;
    assign core1_fs_trim = s_q.core1_fs;
    assign core0_offset_trim = s_q.core0_off;
    assign core1_offset_trim = s_q.core1_off;
    assign chan_a_sample = s_q.sa;
    assign chan_b_sample = s_q.sb;
    assign sample_valid = s_q.valid;
    assign cal_halt = cal_halt_w;
    assign chan_a_high_flag = a_high;
    assign chan_a_low_flag = a_low;
    assign chan_b_high_flag = b_high;
    assign chan_b_low_flag = b_low;
    assign irq = s_q.irq;

    fg_stops_samples_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cal_halt_w |=> !sample_valid && $stable(chan_a_sample))
        else $error("samples delivered during foreground calibration");
    dither_removed_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !cal_halt_w && core0_dither == 12'h000 |=> chan_a_sample ==
        $past(core0_code))
        else $error("zero dither changed the sample");
    swap_routing_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !single_mode_w && s_q.dual_swap |-> core0_input_b && !core1_input_b)
        else $error("swap did not exchange the inputs");
    single_routing_a: assert property (@(posedge hclk) disable iff (!hresetn)
        single_mode_w |-> core1_falling_edge && core0_input_b ==
        s_q.single_input_b && core1_input_b == s_q.single_input_b)
        else $error("single mode routing or edge wrong");
    fs_trim_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        core1_input_b |-> core1_fs_trim == s_q.full_scale_trim_b)
        else $error("core took the trim of the other input");
    shared_thresh_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.valid && magnitude_byte(s_q.sa) >= s_q.low_threshold &&
        magnitude_byte(s_q.sb) >= s_q.low_threshold) |=> a_low && b_low)
        else $error("channels disagree on equal samples");
    neg_full_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_q.valid && s_q.sa == 12'h800) |=> a_high && a_low)
        else $error("most negative code not seen as full magnitude");
    irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        irq == |($past(s_d.irq_status) & $past(s_d.irq_mask)))
        else $error("interrupt does not follow masked status");

    assign single_mode_w = s_q.single_mode;

    cal_fg_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        cal_done && s_q.cal_fg);
    both_flags_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        a_high && b_low);
    irq_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(irq));
endmodule : conv_ctrl_top
`default_nettype wire

// File: conv_ctrl_pkg.sv
// Shared constants, types and helpers of the converter control block.
// Assumes one device clock; every consumer imports the whole package.
`default_nettype none
package conv_ctrl_pkg;
    // Register byte offsets on the register bus.
    localparam logic [11:0] MODE_CTRL_OFS = 12'h000;
    localparam logic [11:0] INPUT_ROUTING_OFS = 12'h004;
    localparam logic [11:0] OVR_THRESH_OFS = 12'h008;
    localparam logic [11:0] OVR_CFG_OFS = 12'h00c;
    localparam logic [11:0] FS_TRIM_A_OFS = 12'h010;
    localparam logic [11:0] FS_TRIM_B_OFS = 12'h014;
    localparam logic [11:0] STATUS_OFS = 12'h018;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h01c;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h020;
    localparam logic [11:0] OFFSET_TRIM_FIRST = 12'h330;
    localparam logic [11:0] OFFSET_TRIM_LAST = 12'h34f;
    // Field positions.
    localparam int MODE_SINGLE_BIT = 0;
    localparam int MODE_CAL_FG_BIT = 1;
    localparam int MODE_CAL_START_BIT = 2;
    localparam int ROUTE_SINGLE_B_BIT = 0;
    localparam int ROUTE_SWAP_BIT = 4;
    localparam int THRESH_LOW_POS = 8;
    localparam int IRQ_CAL_DONE_BIT = 4;
    // Values after reset.
    localparam logic [15:0] FS_TRIM_RESET = 16'ha000;
    localparam logic [7:0] THRESH_RESET = 8'hff;
    localparam logic [2:0] HOLD_EXP_RESET = 3'h0;
    // Shortest flag pulse, in device clock cycles, before scaling by 2^N.
    localparam logic [10:0] HOLD_BASE_CYCLES = 11'h008;
    // Count loaded at start; the run phase lasts this plus one device clock cycles.
    localparam logic [9:0] CAL_CYCLES = 10'h3ff;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b11
    } cal_state_type;

    // Eight upper bits of the 11-bit magnitude of a two's complement code.
    function automatic logic [7:0] magnitude_byte(input logic [11:0] code);
        logic [10:0] mag;
        mag = 11'h000;
        if (code == 12'h800) begin
            mag = 11'h7ff;
        end else if (code[11]) begin
            mag = 11'((~code[10:0]) + 11'h001);
        end else begin
            mag = code[10:0];
        end
        return mag[10:3];
    endfunction : magnitude_byte

    // Removes the injected dither, saturating at the code limits.
    function automatic logic [11:0] remove_dither(input logic [11:0] raw,
                                                  input logic [11:0] dith);
        logic [12:0] diff;
        diff = {raw[11], raw} - {dith[11], dith};
        if (diff[12] != diff[11]) begin
            return diff[12] ? 12'h800 : 12'h7ff;
        end
        return diff[11:0];
    endfunction : remove_dither
endpackage : conv_ctrl_pkg
`default_nettype wire

// File: ovr_cfg_if.sv
// Threshold and hold settings passed from the register file to monitors.
// Assumes both ends run on the same device clock.
`default_nettype none
interface ovr_cfg_if;
    logic [7:0] high_threshold;
    logic [7:0] low_threshold;
    logic [2:0] flag_hold_exponent;
    modport ctrl (output high_threshold, low_threshold, flag_hold_exponent);
    modport mon (input high_threshold, low_threshold, flag_hold_exponent);
endinterface : ovr_cfg_if
`default_nettype wire

// File: overrange_channel.sv
// Overrange monitor of one channel: two thresholds, two stretched flags.
// Assumes samples arrive from logic on the same clock, qualified by valid.
`default_nettype none
module overrange_channel
    import conv_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [11:0] sample,
    input wire logic sample_valid,
    ovr_cfg_if.mon cfg,
    output logic high_flag,
    output logic low_flag
);
    typedef struct packed {
        logic [10:0] high_cnt;
        logic [10:0] low_cnt;
        logic high_flag;
        logic low_flag;
    } ovr_state_type;

    ovr_state_type s_q, s_d;
    logic [7:0] mag;
    logic high_hit;
    logic low_hit;
    logic [10:0] dur;

    // Compare the upper magnitude bits; equal counts as a crossing.
    always_comb begin
        mag = magnitude_byte(sample);
        high_hit = sample_valid && (mag >= cfg.high_threshold);
        low_hit = sample_valid && (mag >= cfg.low_threshold);
        dur = HOLD_BASE_CYCLES << cfg.flag_hold_exponent;
        s_d = s_q;
        // A crossing reloads the count, so the pulse runs from the last one.
        s_d.high_flag = high_hit || (s_q.high_cnt > 11'h001);
        s_d.low_flag = low_hit || (s_q.low_cnt > 11'h001);
        if (high_hit) begin
            s_d.high_cnt = dur;
        end else if (s_q.high_cnt != 11'h000) begin
            s_d.high_cnt = s_q.high_cnt - 11'h001;
        end
        if (low_hit) begin
            s_d.low_cnt = dur;
        end else if (s_q.low_cnt != 11'h000) begin
            s_d.low_cnt = s_q.low_cnt - 11'h001;
        end
    end

    // Single state register of the monitor.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign high_flag = s_q.high_flag;
    assign low_flag = s_q.low_flag;

    hit_sets_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        high_hit |=> high_flag && s_q.high_cnt == dur)
        else $error("high crossing did not raise its flag");
    flag_hold_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(low_flag) |-> $past(s_q.low_cnt) == 11'h001 && !$past(low_hit))
        else $error("low flag fell before its hold time ran out");
    min_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(high_flag) |-> high_flag [*8])
        else $error("high flag pulse shorter than eight cycles");
    restart_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (low_hit && low_flag) |=> s_q.low_cnt == $past(dur))
        else $error("crossing during a pulse did not restart the hold");
    stretch_cover_c: cover property (@(posedge hclk) disable iff (!hresetn)
        high_flag && high_hit);
endmodule : overrange_channel
`default_nettype wire

// File: cal_sequencer.sv
// Calibration pass sequencer: runs a fixed pass, reports busy and done.
// Assumes start is a one-cycle pulse from the register file.
`default_nettype none
module cal_sequencer
    import conv_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic foreground,
    output logic busy,
    output logic halt,
    output logic done
);
    typedef struct packed {
        cal_state_type state;
        logic [9:0] cnt;
        logic halt;
        logic done;
    } cal_reg_type;

    cal_reg_type s_q, s_d;

    // Idle, run for a fixed pass, then one done cycle.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.state)
            CAL_IDLE: begin
                if (start) begin
                    s_d.state = CAL_RUN;
                    s_d.cnt = CAL_CYCLES;
                    s_d.halt = foreground;
                end
            end
            CAL_RUN: begin
                if (s_q.cnt == 10'h000) begin
                    s_d.state = CAL_DONE;
                    s_d.halt = 1'b0;
                    s_d.done = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 10'h001;
                end
            end
            CAL_DONE: begin
                s_d.state = CAL_IDLE;
            end
            default: begin
                s_d.state = CAL_IDLE;
                s_d.halt = 1'b0;
            end
        endcase
    end

    // Single state register of the sequencer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{state: CAL_IDLE, cnt: 10'h000, halt: 1'b0, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.state != CAL_IDLE);
    assign halt = s_q.halt;
    assign done = s_q.done;

    bg_no_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && !foreground && !busy) |=> !halt [*8])
        else $error("background calibration halted sampling");
endmodule : cal_sequencer
`default_nettype wire

// File: flag_watcher.sv
// Downstream logic model that watches the four overrange flags.
// Assumes the flags are levels on the device clock.
`default_nettype none
module flag_watcher (
    input wire logic chan_a_high_flag,
    input wire logic chan_a_low_flag,
    input wire logic chan_b_high_flag,
    input wire logic chan_b_low_flag,
    output logic high_seen,
    output logic low_seen
);
    // Either channel may carry the event in single mode, so OR them.
    assign high_seen = chan_a_high_flag | chan_b_high_flag;
    assign low_seen = chan_a_low_flag | chan_b_low_flag;
endmodule : flag_watcher
`default_nettype wire

// File: tb_top.sv
// Bench: bus access, flag hold, restart and interrupt scenarios.
// Assumes a zero-wait AHB-Lite slave and codes taken every clock.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_ctrl_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [11:0] core0_code = 12'h000, core1_code = 12'h000;
    logic [11:0] core0_dither = 12'h000, core1_dither = 12'h000, sa, sb;
    logic c0b, c1b, c1f, valid, halt;
    logic hreadyout, chan_a_high_flag, chan_a_low_flag, chan_b_high_flag;
    logic chan_b_low_flag, irq, high_seen, low_seen;
    int mismatches = 0, comparisons = 0;
    // Free-running device clock.
    always #5 hclk = ~hclk;
    conv_ctrl_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp(), .core0_code, .core0_dither, .core1_code, .core1_dither,
        .core0_input_b(c0b), .core1_input_b(c1b), .core1_falling_edge(c1f),
        .core0_fs_trim(), .core1_fs_trim(), .core0_offset_trim(),
        .core1_offset_trim(), .chan_a_sample(sa), .chan_b_sample(sb),
        .sample_valid(valid), .cal_halt(halt), .chan_a_high_flag,
        .chan_a_low_flag, .chan_b_high_flag, .chan_b_low_flag, .irq);
    flag_watcher i_watch (.chan_a_high_flag, .chan_a_low_flag,
        .chan_b_high_flag, .chan_b_low_flag, .high_seen, .low_seen);
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Bounded wait so a stuck slave ends the run instead of hanging it.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            mismatches++;
            conclude();
        end
    endtask : wait_ready
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask : bus
    // One or two crossings, then count how long each flag but chan_a_low_flag stands.
    task automatic hold_scn(input logic [2:0] n, input int gap);
        int la, lb, lh, lw;
        la = 0;
        lb = 0;
        lh = 0;
        lw = 0;
        bus(1'b1, OVR_CFG_OFS, {29'h0, n}, rd);
        for (int i = 0; i < 1100; i++) begin
            @(posedge hclk);
            core0_code <= (i == 0 || i == gap) ? 12'h800 : 12'h000;
            core1_code <= (i == 0 || i == gap) ? 12'h200 : 12'h000;
            #1;
            if (chan_a_high_flag === 1'b1) la++;
            if (chan_b_low_flag === 1'b1) lb++;
            if (chan_b_high_flag === 1'b1) lh++;
            if (high_seen === 1'b1) lw++;
        end
        check("a_high_len", 32'(8 << n) + 32'(gap), 32'(la));
        check("b_low_len", 32'(8 << n) + 32'(gap), 32'(lb));
        check("b_high_len", 32'h0, 32'(lh));
        check("high_seen_len", 32'(8 << n) + 32'(gap), 32'(lw));
    endtask : hold_scn
    // Status is sticky; the mask gates the level output.
    task automatic irq_scn();
        bus(1'b0, IRQ_STATUS_OFS, 32'h0, rd);
        check("irq_status", 32'h0000000b, rd);
        check("irq_masked", 32'h0, {31'h0, irq});
        bus(1'b1, IRQ_MASK_OFS, 32'h1, rd);
        repeat (2) @(posedge hclk);
        check("irq_on", 32'h1, {31'h0, irq});
        bus(1'b1, IRQ_STATUS_OFS, 32'h1, rd);
        repeat (2) @(posedge hclk);
        check("irq_off", 32'h0, {31'h0, irq});
        bus(1'b0, IRQ_STATUS_OFS, 32'h0, rd);
        check("irq_cleared", 32'h0000000a, rd);
    endtask : irq_scn
    // Dither removal, routing in both modes and a foreground pass.
    task automatic mode_scn();
        core0_code <= 12'h123;
        core0_dither <= 12'h023;
        core1_code <= 12'hf00;
        core1_dither <= 12'h7ff;
        bus(1'b1, INPUT_ROUTING_OFS, 32'h11, rd);
        @(posedge hclk);
        check("dither", 32'h100, {20'h0, sa});
        check("saturate", 32'h800, {20'h0, sb});
        check("swap", 32'h2, {30'h0, c0b, c1b});
        bus(1'b1, MODE_CTRL_OFS, 32'h7, rd);
        repeat (3) @(posedge hclk);
        check("single", 32'h7, {29'h0, c0b, c1b, c1f});
        check("halt", 32'h2, {30'h0, halt, valid});
        repeat (1100) @(posedge hclk);
        check("resume", 32'h1, {30'h0, halt, valid});
        bus(1'b0, IRQ_STATUS_OFS, 32'h0, rd);
        check("cal_done", 32'h10, rd & 32'h10);
    endtask : mode_scn
    // Main sequence: reset, register defaults, every hold setting, restart.
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, OVR_THRESH_OFS, 32'h0, rd);
        check("thresholds", 32'h0000ffff, rd);
        bus(1'b0, 12'h100, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        bus(1'b1, OVR_THRESH_OFS, 32'h000040f0, rd);
        for (int n = 0; n < 8; n++) begin
            hold_scn(3'(n), 0);
        end
        hold_scn(3'h0, 5);
        irq_scn();
        mode_scn();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
